// ### plf_pkg.sv
package plf_pkg;
  localparam int PLF_AW = 12;
  localparam int PLF_DW = 32;
  localparam int PLF_RW = 8;
  // Register indices; the bus byte address is four times the index
  localparam logic [PLF_AW-1:0] PLF_IDX_ENABLE = 12'h059;
  localparam logic [PLF_AW-1:0] PLF_IDX_RES = 12'h05A;
  localparam logic [PLF_AW-1:0] PLF_IDX_CAP3 = 12'h05B;
  localparam logic [PLF_AW-1:0] PLF_IDX_CAP1 = 12'h05C;
  localparam logic [PLF_AW-1:0] PLF_ADDR_ENABLE = PLF_IDX_ENABLE << 2;
  localparam logic [PLF_AW-1:0] PLF_ADDR_RES = PLF_IDX_RES << 2;
  localparam logic [PLF_AW-1:0] PLF_ADDR_CAP3 = PLF_IDX_CAP3 << 2;
  localparam logic [PLF_AW-1:0] PLF_ADDR_CAP1 = PLF_IDX_CAP1 << 2;
  localparam logic [PLF_RW-1:0] PLF_RST_ENABLE = 8'h41;
  localparam logic [PLF_RW-1:0] PLF_RST_RES = 8'h2F;
  localparam logic [PLF_RW-1:0] PLF_RST_CAP3 = 8'h27;
  localparam logic [PLF_RW-1:0] PLF_RST_CAP1 = 8'h27;
  // Bit 7 unimplemented in all four registers
  localparam logic [PLF_RW-1:0] PLF_IMPL_MASK = 8'h7F;
  localparam int PLF_BIT_REFDIV = 4;
  localparam int PLF_BIT_PLL_EN = 1;
  localparam int PLF_CODE_W = 5;
  localparam logic [1:0] PLF_RESP_OKAY = 2'h0;
  localparam logic [1:0] PLF_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    PLF_W_IDLE = 2'b00,
    PLF_W_RESP = 2'b01
  } plf_wstate_e;
endpackage

// ### plf_reg8.sv
`timescale 1ns/1ps
module plf_reg8 #(
  parameter logic [7:0] RST = 8'h00,
  parameter logic [7:0] MASK = 8'hFF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);
  logic [7:0] q_r;
  logic [7:0] q_nxt;
  always_comb begin
    q_nxt = q_r;
    if (we) begin
      q_nxt = wdata & MASK;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= RST;
    end else begin
      q_r <= q_nxt;
    end
  end
  assign q = q_r;
endmodule

// ### pll_enable_loop_filter_regs.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
// How it works
// - Top bit of every register reads zero
// - Bit 4 one inserts reference divider, else bypass
// - Bit 1 enables PLL, zero at reset
// - Resistor code bits 4-0, default 01111
// - Capacitor three code bits 4-0, default 00111
// - Capacitor one code bits 4-0, default 00111
module pll_enable_loop_filter_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [plf_pkg::PLF_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [plf_pkg::PLF_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [plf_pkg::PLF_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [plf_pkg::PLF_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic pll_enable,
  output logic ref_divider_enable,
  output logic [plf_pkg::PLF_CODE_W-1:0] loop_filter_resistor_code,
  output logic [plf_pkg::PLF_CODE_W-1:0] loop_filter_cap_three_code,
  output logic [plf_pkg::PLF_CODE_W-1:0] loop_filter_cap_one_code,
  output logic [1:0] factory_reserved_bits_res,
  output logic [4:0] factory_reserved_bits_en
);
  import plf_pkg::*;

  plf_wstate_e wst_r, wst_nxt;
  logic aw_have_r, aw_have_nxt;
  logic w_have_r, w_have_nxt;
  logic [PLF_AW-1:0] awaddr_r, awaddr_nxt;
  logic [PLF_RW-1:0] wbyte_r, wbyte_nxt;
  logic wlane_r, wlane_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [PLF_DW-1:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic do_write;
  logic hit_en, hit_res, hit_cap3, hit_cap1;
  logic [PLF_RW-1:0] q_en, q_res, q_cap3, q_cap1;
  logic [PLF_RW-1:0] rd_byte;
  logic rd_hit;
  logic hit_any, commit, ar_take;
  logic [PLF_AW-3:0] ar_word;

  assign s_axi_awready = (wst_r == PLF_W_IDLE) && !aw_have_r;
  assign s_axi_wready = (wst_r == PLF_W_IDLE) && !w_have_r;
  assign s_axi_bvalid = (wst_r == PLF_W_RESP);
  assign s_axi_bresp = bresp_r;

  // Address and data may arrive in either order; commit once both held
  always_comb begin
    wst_nxt = wst_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    awaddr_nxt = awaddr_r;
    wbyte_nxt = wbyte_r;
    wlane_nxt = wlane_r;
    bresp_nxt = bresp_r;
    do_write = 1'b0;
    case (wst_r)
      PLF_W_IDLE: begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_have_nxt = 1'b1;
          awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_have_nxt = 1'b1;
          wbyte_nxt = s_axi_wdata[PLF_RW-1:0];
          wlane_nxt = s_axi_wstrb[0];
        end
        if (aw_have_r && w_have_r) begin
          do_write = wlane_r;
          aw_have_nxt = 1'b0;
          w_have_nxt = 1'b0;
          bresp_nxt = (hit_en || hit_res || hit_cap3 || hit_cap1) ?
                      PLF_RESP_OKAY : PLF_RESP_SLVERR;
          wst_nxt = PLF_W_RESP;
        end
      end
      PLF_W_RESP: begin
        if (s_axi_bready) begin
          wst_nxt = PLF_W_IDLE;
        end
      end
      default: begin
        wst_nxt = PLF_W_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r <= PLF_W_IDLE;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= '0;
      wbyte_r <= '0;
      wlane_r <= 1'b0;
      bresp_r <= PLF_RESP_OKAY;
    end else begin
      wst_r <= wst_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      awaddr_r <= awaddr_nxt;
      wbyte_r <= wbyte_nxt;
      wlane_r <= wlane_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  assign hit_en = (awaddr_r[PLF_AW-1:2] == PLF_ADDR_ENABLE[PLF_AW-1:2]);
  assign hit_res = (awaddr_r[PLF_AW-1:2] == PLF_ADDR_RES[PLF_AW-1:2]);
  assign hit_cap3 = (awaddr_r[PLF_AW-1:2] == PLF_ADDR_CAP3[PLF_AW-1:2]);
  assign hit_cap1 = (awaddr_r[PLF_AW-1:2] == PLF_ADDR_CAP1[PLF_AW-1:2]);
  // Observation terms for the checks at the bottom
  assign hit_any = hit_en || hit_res || hit_cap3 || hit_cap1;
  assign commit = aw_have_r && w_have_r && (wst_r == PLF_W_IDLE);
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign ar_word = s_axi_araddr[PLF_AW-1:2];

  // Mask drops bit 7 on write so it never stores
  plf_reg8 #(.RST(PLF_RST_ENABLE), .MASK(PLF_IMPL_MASK)) u_en (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(do_write && hit_en),
    .wdata(wbyte_r),
    .q(q_en)
  );
  plf_reg8 #(.RST(PLF_RST_RES), .MASK(PLF_IMPL_MASK)) u_res (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(do_write && hit_res),
    .wdata(wbyte_r),
    .q(q_res)
  );
  plf_reg8 #(.RST(PLF_RST_CAP3), .MASK(PLF_IMPL_MASK)) u_cap3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(do_write && hit_cap3),
    .wdata(wbyte_r),
    .q(q_cap3)
  );
  plf_reg8 #(.RST(PLF_RST_CAP1), .MASK(PLF_IMPL_MASK)) u_cap1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(do_write && hit_cap1),
    .wdata(wbyte_r),
    .q(q_cap1)
  );

  assign pll_enable = q_en[PLF_BIT_PLL_EN];
  assign ref_divider_enable = q_en[PLF_BIT_REFDIV];
  assign loop_filter_resistor_code = q_res[PLF_CODE_W-1:0];
  assign loop_filter_cap_three_code = q_cap3[PLF_CODE_W-1:0];
  assign loop_filter_cap_one_code = q_cap1[PLF_CODE_W-1:0];
  // Factory fields are stored as written; keeping them is software's job
  assign factory_reserved_bits_res = q_res[6:5];
  assign factory_reserved_bits_en = {q_en[6:5], q_en[3:2], q_en[0]};

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr[PLF_AW-1:2])
      PLF_ADDR_ENABLE[PLF_AW-1:2]: rd_byte = q_en;
      PLF_ADDR_RES[PLF_AW-1:2]: rd_byte = q_res;
      PLF_ADDR_CAP3[PLF_AW-1:2]: rd_byte = q_cap3;
      PLF_ADDR_CAP1[PLF_AW-1:2]: rd_byte = q_cap1;
      default: begin
        rd_byte = '0;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      // Top bit forced to zero; upper lanes read zero
      rdata_nxt = {{(PLF_DW-PLF_RW){1'b0}}, rd_byte & PLF_IMPL_MASK};
      rresp_nxt = rd_hit ? PLF_RESP_OKAY : PLF_RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= PLF_RESP_OKAY;
    end else begin
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  top_bit_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[7] == 1'b0)
    else $error("top bit read as one");
  pll_off_reset_a: assert property (@(posedge aclk)
    $rose(aresetn) |-> !pll_enable && !ref_divider_enable)
    else $error("enable bits not cleared by reset");
  res_default_a: assert property (@(posedge aclk)
    $rose(aresetn) |-> loop_filter_resistor_code == 5'h0F)
    else $error("resistor default wrong");
  cap_default_a: assert property (@(posedge aclk)
    $rose(aresetn) |-> loop_filter_cap_three_code == 5'h07
      && loop_filter_cap_one_code == 5'h07)
    else $error("capacitor default wrong");
  en_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && hit_en |=> pll_enable == $past(wbyte_r[1])
      && ref_divider_enable == $past(wbyte_r[4]))
    else $error("enable register write lost");
  code_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && hit_cap1 |=> loop_filter_cap_one_code == $past(wbyte_r[4:0]))
    else $error("cap one write lost");
  cap3_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && hit_cap3 |=> loop_filter_cap_three_code == $past(wbyte_r[4:0]))
    else $error("cap three write lost");
  no_write_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !do_write |=> $stable(q_en) && $stable(q_res) && $stable(q_cap3) && $stable(q_cap1))
    else $error("state changed without write");
  bresp_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    aw_have_r && w_have_r && wst_r == PLF_W_IDLE |=> s_axi_bvalid)
    else $error("write response late");
  res_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && hit_res |=> loop_filter_resistor_code == $past(wbyte_r[4:0]))
    else $error("resistor write lost");
  fcb_en_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && hit_en |=> factory_reserved_bits_en
      == {$past(wbyte_r[6:5]), $past(wbyte_r[3:2]), $past(wbyte_r[0])})
    else $error("enable factory bits not stored");
  fcb_res_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    do_write && hit_res |=> factory_reserved_bits_res == $past(wbyte_r[6:5]))
    else $error("resistor factory bits not stored");
  top_bit_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !q_en[7] && !q_res[7] && !q_cap3[7] && !q_cap1[7])
    else $error("top bit stored");
  rdata_upper_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[PLF_DW-1:PLF_RW] == '0)
    else $error("upper read lanes not zero");
  read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  ar_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  aw_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready && !aw_have_r && !w_have_r)
    else $error("write taken while response pending");
  unmapped_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rresp == PLF_RESP_SLVERR |-> s_axi_rdata == '0)
    else $error("unmapped read not zero");
  read_en_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && ar_word == PLF_ADDR_ENABLE[PLF_AW-1:2]
      |=> s_axi_rdata[6:0] == $past(q_en[6:0]) && s_axi_rresp == PLF_RESP_OKAY)
    else $error("enable register read wrong");
  read_res_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && ar_word == PLF_ADDR_RES[PLF_AW-1:2]
      |=> s_axi_rdata[6:0] == $past(q_res[6:0]) && s_axi_rresp == PLF_RESP_OKAY)
    else $error("resistor register read wrong");
  read_cap3_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && ar_word == PLF_ADDR_CAP3[PLF_AW-1:2]
      |=> s_axi_rdata[6:0] == $past(q_cap3[6:0]) && s_axi_rresp == PLF_RESP_OKAY)
    else $error("cap three register read wrong");
  read_cap1_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ar_take && ar_word == PLF_ADDR_CAP1[PLF_AW-1:2]
      |=> s_axi_rdata[6:0] == $past(q_cap1[6:0]) && s_axi_rresp == PLF_RESP_OKAY)
    else $error("cap one register read wrong");
  reset_value_a: assert property (@(posedge aclk)
    $rose(aresetn) |-> q_en == PLF_RST_ENABLE && q_res == PLF_RST_RES
      && q_cap3 == PLF_RST_CAP3 && q_cap1 == PLF_RST_CAP1)
    else $error("register reset value wrong");
  unmapped_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    commit && !hit_any |=> s_axi_bresp == PLF_RESP_SLVERR && $stable(q_en)
      && $stable(q_res) && $stable(q_cap3) && $stable(q_cap1))
    else $error("unmapped write not refused");
  aw_single_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready && awaddr_r == $past(s_axi_awaddr))
    else $error("write address not held");
  w_single_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_wvalid && s_axi_wready |=> !s_axi_wready && wbyte_r == $past(s_axi_wdata[7:0]))
    else $error("write data not held");
  read_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer not released");
  write_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
endmodule

// ### test_pll_enable_loop_filter_regs.sv
`timescale 1ns/1ps
module test_pll_enable_loop_filter_regs;
  import plf_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [PLF_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [PLF_DW-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, factory_reserved_bits_res;
  logic pll_enable, ref_divider_enable;
  logic [4:0] loop_filter_resistor_code, loop_filter_cap_three_code;
  logic [4:0] loop_filter_cap_one_code, factory_reserved_bits_en;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [7:0] mdl [4];
  logic [PLF_AW-1:0] adr [4] = '{PLF_ADDR_ENABLE, PLF_ADDR_RES, PLF_ADDR_CAP3, PLF_ADDR_CAP1};
  logic [7:0] rstv [4] = '{PLF_RST_ENABLE, PLF_RST_RES, PLF_RST_CAP3, PLF_RST_CAP1};

  pll_enable_loop_filter_regs u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pll_enable, .ref_divider_enable,
    .loop_filter_resistor_code, .loop_filter_cap_three_code, .loop_filter_cap_one_code,
    .factory_reserved_bits_res, .factory_reserved_bits_en
  );

  always #2.5 aclk = ~aclk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t resp got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    n_mismatch++;
    $display("CHECK FAILED t=%0t bus wait timed out", $time);
    stop_test();
  endtask

  // Ready is sampled at the falling edge, so the rising edge decision never races
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    bit ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    tb = 1'b0;
    for (int n = 0; n < 50 && !tb; n++) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid === 1'b1;
      if (tb) chk_resp(s_axi_bresp, er);
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!tb) hang();
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    bit ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    tr = 1'b0;
    for (int n = 0; n < 50 && !tr; n++) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid === 1'b1;
      if (tr) chk_val(s_axi_rdata, exp, "read data");
      if (tr) chk_resp(s_axi_rresp, er);
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!tr) hang();
  endtask

  task automatic chk_all();
    logic [4:0] fcb_exp;
    for (int i = 0; i < 4; i++) rd(adr[i], {24'h0, mdl[i]}, PLF_RESP_OKAY);
    chk_val(32'(pll_enable), 32'(mdl[0][PLF_BIT_PLL_EN]), "pll");
    chk_val(32'(ref_divider_enable), 32'(mdl[0][PLF_BIT_REFDIV]), "refdiv");
    chk_val(32'(loop_filter_resistor_code), 32'(mdl[1][4:0]), "res");
    chk_val(32'(loop_filter_cap_three_code), 32'(mdl[2][4:0]), "cap3");
    chk_val(32'(loop_filter_cap_one_code), 32'(mdl[3][4:0]), "cap1");
    chk_val(32'(factory_reserved_bits_res), 32'(mdl[1][6:5]), "fcb res");
    fcb_exp = {mdl[0][6:5], mdl[0][3:2], mdl[0][0]};
    chk_val(32'(factory_reserved_bits_en), 32'(fcb_exp), "fcb en");
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    mdl = rstv;
  endtask

  initial begin
    logic [31:0] d;
    int i;
    void'($urandom(93638));
    do_reset();
    chk_all();
    $display("test reset values done");
    for (int k = 0; k < 28; k++) begin
      i = k % 4;
      d = $urandom;
      if (k < 4) d[7:0] = 8'hFF;
      else if (k < 8) d[7:0] = 8'h00;
      // Host side keeps factory fields as they power up
      d[6:5] = rstv[i][6:5];
      if (i == 0) {d[3:2], d[0]} = {rstv[0][3:2], rstv[0][0]};
      wr(adr[i] | 12'($urandom % 4), d, 4'h1 | 4'($urandom), PLF_RESP_OKAY);
      mdl[i] = d[7:0] & PLF_IMPL_MASK;
      chk_all();
    end
    $display("test random writes done");
    // Lane 0 off: nothing stored, factory field still kept by the host
    wr(adr[1], {24'hFFFFFF, 1'b1, rstv[1][6:5], ~mdl[1][4:0]}, 4'hE, PLF_RESP_OKAY);
    wr(12'h174, 32'h7F, 4'hF, PLF_RESP_SLVERR);
    rd(12'h174, 32'h0, PLF_RESP_SLVERR);
    rd(12'h160, 32'h0, PLF_RESP_SLVERR);
    chk_all();
    $display("test refused accesses done");
    do_reset();
    chk_all();
    $display("test second reset done");
    stop_test();
  end
endmodule
